// ==== pmx_pin_setup.sv ====
// Purpose: Port pin alternate-function setup with AXI4-Lite registers
// Assumes: Pin and peripheral inputs are synchronous to aclk
// Notes:   All outputs are registered; one cycle from settings to pins
//
// Behaviour
// R1: Alternate use follows direction and latch bits
// R2: Nonmaskable input sampled when direction is input
// R3: Interrupt and trigger inputs need direction input
// R4: Serial clock zero; I2C needs open-drain select
// R5: Serial clock one and baud clock likewise
// R6: Alternate outputs need direction 0, latch 0
// R7: Voltage monitor output also needs its enable
// R8: Bus pins follow expansion mode; strobes latch 1
// R9: Analog pins have no direction bit

`timescale 1ns/1ps

module pmx_pin_setup #(
  parameter int AW = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [AW-1:0]       s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AW-1:0]       s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [79:0]         pin_in,
  output logic [79:0]              pin_out,
  output logic [79:0]              pin_oe,
  input  wire pmx_pkg::pmx_drive_t periph_drive,
  input  wire pmx_pkg::pmx_drive_t bus_drive,
  output logic [79:0]              alt_in
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Kind of register: 0 dir, 1 latch, 2 pin, 3 ctrl, 4 unmapped
  function automatic logic [2:0] reg_kind(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    if (b == pmx_pkg::CTRL_OFF) begin
      return 3'h3;
    end
    if (b[1:0] != 2'h0 || b[5:2] >= 4'(pmx_pkg::NPORT)) begin
      return 3'h4;
    end
    case (b[7:6])
      2'h0:    return 3'h0;
      2'h1:    return 3'h1;
      2'h2:    return 3'h2;
      default: return 3'h4;
    endcase
  endfunction : reg_kind

  // Port number held in an address
  function automatic logic [3:0] reg_port(input logic [AW-1:0] a);
    return a[5:2];
  endfunction : reg_port

  // ****************************************************************
  // State
  // ****************************************************************
  logic [79:0]         dir_q,   dir_d;
  logic [79:0]         lat_q,   lat_d;
  logic [3:0]          ctrl_q,  ctrl_d;
  logic [79:0]         pin_q,   pin_d;
  logic                awr_q,   awr_d;
  logic                bval_q,  bval_d;
  logic [1:0]          bresp_q, bresp_d;
  logic                arr_q,   arr_d;
  logic                rval_q,  rval_d;
  logic [1:0]          rresp_q, rresp_d;
  logic [31:0]         rdata_q, rdata_d;
  logic [79:0]         out_q,   oe_q,    ain_q;
  pmx_pkg::pmx_cfg_t   cfg;
  pmx_pkg::pmx_drive_t drv;
  logic [79:0]         ain;

  // ****************************************************************
  // Pin multiplexer
  // ****************************************************************

  // Settings gathered for the selection logic
  always_comb begin
    cfg.dir     = dir_q;  // R1
    cfg.lat     = lat_q;  // R1
    cfg.data_od = ctrl_q[pmx_pkg::CTRL_DATA_OD_BIT];  // R4
    cfg.clk_od  = ctrl_q[pmx_pkg::CTRL_CLK_OD_BIT];   // R4
    cfg.vmon_en = ctrl_q[pmx_pkg::CTRL_VMON_BIT];     // R7
    cfg.memx_en = ctrl_q[pmx_pkg::CTRL_MEMX_BIT];     // R8
  end

  pmx_core u_core (
    .cfg    (cfg),
    .periph (periph_drive),
    .bus    (bus_drive),
    .pin_in (pin_q),
    .drive  (drv),
    .alt_in (ain)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************

  // Next values of registers and bus handshakes
  always_comb begin
    logic [2:0] wk;
    logic [2:0] rk;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [7:0] wb;
    wk = reg_kind(s_axi_awaddr);
    rk = reg_kind(s_axi_araddr);
    wp = reg_port(s_axi_awaddr);
    rp = reg_port(s_axi_araddr);
    wb = s_axi_wdata[7:0];
    dir_d   = dir_q;
    lat_d   = lat_q;
    ctrl_d  = ctrl_q;
    pin_d   = pin_in;
    awr_d   = 1'b0;
    bval_d  = bval_q && !s_axi_bready;
    bresp_d = bresp_q;
    arr_d   = 1'b0;
    rval_d  = rval_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    // Take address and data together, one write in flight
    if (s_axi_awvalid && s_axi_wvalid && !awr_q && !bval_q) begin
      awr_d = 1'b1;
    end
    if (awr_q) begin
      bval_d  = 1'b1;
      bresp_d = (wk == 3'h4) ? pmx_pkg::RESP_SLVERR : pmx_pkg::RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        case (wk)
          3'h0: begin
            dir_d[wp*8 +: 8] = wb;  // R1
          end
          3'h1: begin
            lat_d[wp*8 +: 8] = wb;  // R1
          end
          3'h3: begin
            ctrl_d = wb[3:0];
          end
          default: begin
            ctrl_d = ctrl_q;
          end
        endcase
      end
      dir_d = dir_d | pmx_pkg::NODIR_MASK;  // R9
    end
    // Read address taken, data follows next cycle
    if (s_axi_arvalid && !arr_q && !rval_q) begin
      arr_d = 1'b1;
    end
    if (arr_q) begin
      rval_d  = 1'b1;
      rresp_d = (rk == 3'h4) ? pmx_pkg::RESP_SLVERR : pmx_pkg::RESP_OKAY;
      case (rk)
        3'h0: begin
          rdata_d = {24'h0, dir_q[rp*8 +: 8] &
                     ~pmx_pkg::NODIR_MASK[rp*8 +: 8]};
        end
        3'h1: begin
          rdata_d = {24'h0, lat_q[rp*8 +: 8]};
        end
        3'h2: begin
          rdata_d = {24'h0, pin_q[rp*8 +: 8]};
        end
        3'h3: begin
          rdata_d = {28'h0, ctrl_q};
        end
        default: begin
          rdata_d = 32'h0;
        end
      endcase
    end
  end

  // Register everything, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q   <= {pmx_pkg::NPORT{pmx_pkg::DIR_RST}};
      lat_q   <= {pmx_pkg::NPORT{pmx_pkg::LAT_RST}};
      ctrl_q  <= pmx_pkg::CTRL_RST;
      pin_q   <= 80'h0;
      awr_q   <= 1'b0;
      bval_q  <= 1'b0;
      bresp_q <= pmx_pkg::RESP_OKAY;
      arr_q   <= 1'b0;
      rval_q  <= 1'b0;
      rresp_q <= pmx_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
      out_q   <= 80'h0;
      oe_q    <= 80'h0;
      ain_q   <= 80'h0;
    end else begin
      dir_q   <= dir_d;
      lat_q   <= lat_d;
      ctrl_q  <= ctrl_d;
      pin_q   <= pin_d;
      awr_q   <= awr_d;
      bval_q  <= bval_d;
      bresp_q <= bresp_d;
      arr_q   <= arr_d;
      rval_q  <= rval_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      out_q   <= drv.out;  // R6 R8
      oe_q    <= drv.oe;   // R6 R8
      ain_q   <= ain;      // R2 R3
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Straight from flip-flops
  always_comb begin
    s_axi_awready = awr_q;
    s_axi_wready  = awr_q;
    s_axi_bvalid  = bval_q;
    s_axi_bresp   = bresp_q;
    s_axi_arready = arr_q;
    s_axi_rvalid  = rval_q;
    s_axi_rresp   = rresp_q;
    s_axi_rdata   = rdata_q;
    pin_out       = out_q;
    pin_oe        = oe_q;
    alt_in        = ain_q;
  end

endmodule : pmx_pin_setup

// ==== pmx_pkg.sv ====
// Purpose: Shared constants and carriers for the port pin multiplexer
// Assumes: Ten ports of up to eight pins, packed into one 80-bit vector
// Notes:   Pin index is port * 8 + bit; absent bits are inert

package pmx_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NPORT = 10;
  localparam int PW    = 8;
  localparam int NPIN  = NPORT * PW;

  // Bits that exist on each port (port 9 leftmost)
  localparam logic [79:0] PIN_EXISTS = 80'h7f0fff3fffff1fff3fff;
  // Analog-only ports 7 and 8 carry no direction bit
  localparam logic [79:0] NODIR_MASK = 80'h000fff00000000000000;
  // External bus pins on ports 4, 5, 6 and 9
  localparam logic [79:0] EXTBUS_MASK = 80'h7f00003fffff00000000;

  // ****************************************************************
  // Special pin indices
  // ****************************************************************
  localparam int PIN_I2C_DATA  = 8;   // Port 1 bit 0
  localparam int PIN_I2C_CLOCK = 10;  // Port 1 bit 2
  localparam int PIN_VMON      = 28;  // Port 3 bit 4
  localparam int PIN_DSTROBE   = 75;  // Port 9 bit 3
  localparam int PIN_ASTROBE   = 76;  // Port 9 bit 4

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] DIR_BASE = 8'h00;  // port_direction_reg n
  localparam logic [7:0] LAT_BASE = 8'h40;  // port_output_latch n
  localparam logic [7:0] PIN_BASE = 8'h80;  // Pin level readback n
  localparam logic [7:0] CTRL_OFF = 8'hc0;  // Control bits

  localparam int CTRL_DATA_OD_BIT = 0;  // data_pin_open_drain_sel
  localparam int CTRL_CLK_OD_BIT  = 1;  // clock_pin_open_drain_sel
  localparam int CTRL_VMON_BIT    = 2;  // voltage_monitor_ctrl enable
  localparam int CTRL_MEMX_BIT    = 3;  // memory_expansion_mode enable

  // ****************************************************************
  // Reset values and responses
  // ****************************************************************
  localparam logic [7:0] DIR_RST  = 8'hff;  // All pins input
  localparam logic [7:0] LAT_RST  = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [79:0] out;
    logic [79:0] oe;
  } pmx_drive_t;

  typedef struct packed {
    logic [79:0] dir;
    logic [79:0] lat;
    logic        data_od;
    logic        clk_od;
    logic        vmon_en;
    logic        memx_en;
  } pmx_cfg_t;

endpackage : pmx_pkg

// ==== pmx_core.sv ====
// Purpose: Per-pin selection between port, alternate and bus functions
// Assumes: Purely combinational; the top registers every result
// Notes:   Peripheral oe means the peripheral wants its output on the pin

`timescale 1ns/1ps

module pmx_core (
  input  wire pmx_pkg::pmx_cfg_t   cfg,
  input  wire pmx_pkg::pmx_drive_t periph,
  input  wire pmx_pkg::pmx_drive_t bus,
  input  wire logic [79:0]         pin_in,
  output pmx_pkg::pmx_drive_t      drive,
  output logic [79:0]              alt_in
);

  // ****************************************************************
  // Pin selection
  // ****************************************************************

  // Decide drive and input routing for every pin
  always_comb begin
    logic od;
    logic sel;
    logic strobe;
    od = 1'b0;
    sel = 1'b0;
    strobe = 1'b0;
    drive = '0;
    alt_in = '0;
    for (int i = 0; i < pmx_pkg::NPIN; i++) begin
      od = (i == pmx_pkg::PIN_I2C_DATA && cfg.data_od) ||
           (i == pmx_pkg::PIN_I2C_CLOCK && cfg.clk_od);
      sel = (i == pmx_pkg::PIN_VMON) ? cfg.vmon_en : periph.oe[i];
      strobe = (i == pmx_pkg::PIN_DSTROBE) || (i == pmx_pkg::PIN_ASTROBE);
      if (!pmx_pkg::PIN_EXISTS[i]) begin
        drive.oe[i] = 1'b0;
      end else if (pmx_pkg::NODIR_MASK[i]) begin
        alt_in[i] = pin_in[i];  // R9
      end else if (cfg.memx_en && pmx_pkg::EXTBUS_MASK[i] &&
                   !(strobe && !cfg.lat[i])) begin
        drive.out[i] = bus.out[i];  // R8
        drive.oe[i]  = bus.oe[i];   // R8
        alt_in[i]    = pin_in[i];
      end else if (cfg.dir[i]) begin
        alt_in[i] = pin_in[i];  // R1 R2 R3 R4 R5 R6
      end else if (!cfg.lat[i] && sel) begin
        if (od) begin
          drive.oe[i] = !periph.out[i];  // R4
          alt_in[i]   = pin_in[i];       // R4
        end else begin
          drive.out[i] = periph.out[i];  // R6 R7
          drive.oe[i]  = 1'b1;           // R6 R7
        end
      end else begin
        drive.out[i] = cfg.lat[i];  // R1
        drive.oe[i]  = 1'b1;
      end
    end
  end

endmodule : pmx_core

// ==== pmx_pin_setup_properties.sv ====
// Purpose: Port-level assertions for the pin setup block
// Assumes: Bound to every instance of pmx_pin_setup
// Notes:   Settings are internal, so bus timing and fixed pins are watched
`timescale 1ns/1ps

module pmx_pin_setup_properties #(
  parameter int AW = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [79:0] pin_in,
  input wire logic [79:0] pin_oe,
  input wire logic [79:0] alt_in
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  sequence s_wr_take;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  a_wr_resp_next: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
  a_rd_resp_next: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready
    && $past(s_axi_awvalid)) else $error("address and data split");
  a_ready_pulse: assert property (s_wr_take |=> !s_axi_awready)
    else $error("write ready too long");
  a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

  // ****************************************************************
  // Fixed pins
  // ****************************************************************
  a_absent_idle: assert property ((((pin_oe | alt_in) &
    ~pmx_pkg::PIN_EXISTS)) == 80'h0) else $error("absent pin active");
  a_analog_no_out: assert property ((pin_oe & pmx_pkg::NODIR_MASK)
    == 80'h0) else $error("analog pin driven");
  a_analog_follow: assert property ($past(aresetn) && $past(aresetn, 2)
    |-> (alt_in & pmx_pkg::NODIR_MASK) ==
        ($past(pin_in, 2) & pmx_pkg::NODIR_MASK))
    else $error("analog input not routed");
endmodule : pmx_pin_setup_properties

bind pmx_pin_setup pmx_pin_setup_properties #(.AW(AW)) u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_in, .pin_oe, .alt_in
);

// ==== pmx_periph_model.sv ====
// Purpose: Peripherals, bus controller and board pins around the block
// Assumes: Controls change just after a clock edge
// Notes:   Fixed output patterns so every expectation is known
`timescale 1ns/1ps

module pmx_periph_model #(
  parameter logic [79:0] PER_PAT = {10{8'h5b}},
  parameter logic [79:0] BUS_PAT = {10{8'ha4}}
) (
  input wire logic [79:0]   req,
  input wire logic          bus_on,
  input wire logic [79:0]   ext_lvl,
  output pmx_pkg::pmx_drive_t periph_drive,
  output pmx_pkg::pmx_drive_t bus_drive,
  output logic [79:0]       pin_in
);
  // Peripheral outputs and their requests to drive
  assign periph_drive.out = PER_PAT;
  assign periph_drive.oe  = req;
  // Bus controller drives only bus pins
  assign bus_drive.out = BUS_PAT;
  assign bus_drive.oe  = bus_on ? pmx_pkg::EXTBUS_MASK : 80'h0;
  // Board levels
  assign pin_in = ext_lvl;
endmodule : pmx_periph_model

// ==== tb.sv ====
// Purpose: Self-checking bench for the pin setup block
// Assumes: AXI4-Lite master tasks, fixed peripheral patterns
// Notes:   Expectations follow the selection rules per pin
`timescale 1ns/1ps

module tb;
  localparam logic [79:0] PAT = {10{8'h5b}};
  localparam logic [79:0] BPAT = ~PAT;
  localparam logic [1:0] OK = pmx_pkg::RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, bus_on = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [79:0] req = 80'h0, ext = {10{8'h96}};
  logic [3:0] strb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [79:0] pin_in, pin_out, pin_oe, alt_in;
  pmx_pkg::pmx_drive_t periph_drive, bus_drive;
  int num_errors = 0, tests_run = 0;

  // Clock at 50 MHz
  initial begin
    forever #10 aclk = ~aclk;
  end

  pmx_periph_model #(.PER_PAT(PAT), .BUS_PAT(BPAT)) u_model (
    .req(req), .bus_on(bus_on), .ext_lvl(ext),
    .periph_drive(periph_drive), .bus_drive(bus_drive), .pin_in(pin_in));

  pmx_pin_setup DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_drive(periph_drive), .bus_drive(bus_drive), .alt_in(alt_in));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [79:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, rs);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, rs);
    @(posedge aclk);
  endtask : rd

  // Let settings reach the pins
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 32'hff, OK);
    rd(8'h40, 32'h0, OK);
    rd(8'hc0, 32'h0, OK);
    rd(8'hd0, 32'h0, pmx_pkg::RESP_SLVERR);
    wr(8'hd0, 32'hff, pmx_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h0, OK);
    rd(8'h1c, 32'h0, OK);
    settle();
    chk("nmi_irq_in", alt_in[7:0], 8'h96);
    wr(8'h40, 32'hff, OK);
    settle();
    chk("irq_in_lat", alt_in[7:0], 8'h96);
    chk("irq_oe", pin_oe[7:0], 8'h0);
    strb <= 4'he;
    wr(8'h40, 32'h0, OK);
    strb <= 4'hf;
    rd(8'h40, 32'hff, OK);
    wr(8'h00, 32'h0, OK);
    settle();
    chk("p0_oe", pin_oe[7:0], 8'hff);
    chk("p0_out", pin_out[7:0], 8'hff);
    chk("p0_alt", alt_in[7:0], 8'h0);
    rd(8'h80, 32'h96, OK);
    req <= {80{1'b1}};
    wr(8'h04, 32'h0, OK);
    settle();
    chk("p1_oe", pin_oe[13:8], 6'h3f);
    chk("p1_out", pin_out[13:8], PAT[13:8]);
    wr(8'hc0, 32'h3, OK);
    settle();
    chk("i2c_oe", pin_oe[13:8], 6'h3e);
    chk("i2c_out", pin_out[13:8], PAT[13:8] & 6'h3a);
    wr(8'h44, 32'h04, OK);
    settle();
    chk("lat_out", pin_out[13:8], 6'h1e);
    wr(8'h04, 32'h24, OK);
    settle();
    chk("sck_oe", pin_oe[13:8], 6'h1a);
    chk("sck_in", alt_in[13:8], 6'h04);
    wr(8'h0c, 32'h0, OK);
    settle();
    chk("vmon_off", {pin_oe[28], pin_out[28]}, 2'b10);
    wr(8'hc0, 32'h4, OK);
    settle();
    chk("vmon_on", {pin_oe[28], pin_out[28]}, {1'b1, PAT[28]});
    bus_on <= 1'b1;
    wr(8'hc0, 32'h8, OK);
    settle();
    chk("bus_oe", pin_oe[53:32], {22{1'b1}});
    chk("bus_out", pin_out[53:32], BPAT[53:32]);
    chk("strobe_oe", pin_oe[78:72], 7'h67);
    wr(8'h64, 32'h18, OK);
    settle();
    chk("strobe_on", pin_oe[78:72], 7'h7f);
    chk("p9_out", pin_out[78:72], BPAT[78:72]);
    bus_on <= 1'b0;
    ext <= {10{8'h69}};
    settle();
    chk("bus_idle", pin_oe[53:32], 22'h0);
    chk("ana_in", alt_in[67:56], ext[67:56]);
    chk("ana_oe", pin_oe[67:56], 12'h0);
    wrap_up();
  end
endmodule : tb
